/* rtl/mmc_pkg.sv */
// Constants, register map and carrier types of the module management control block
package mmc_pkg;

  // Main clock
  localparam int CLOCK_PERIOD_NS = 100;

  // Initialization time after power on or module reset release
  localparam int INIT_TIME_MS    = 2000;
  localparam int INIT_CYCLES_DEF = INIT_TIME_MS * (1000000 / CLOCK_PERIOD_NS);
  localparam int INIT_CNT_W      = 25;
  typedef logic [INIT_CNT_W-1:0] mmc_init_cnt_t;

  // Minimum low pulse on the module reset pin, least time rounded up
  localparam int RESET_MIN_US           = 2;
  localparam logic [7:0] RESET_MIN_CYCLES =
    8'((RESET_MIN_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [7:0] LOW_CNT_MAX    = 8'hff;

  // Serial management byte addresses (lower page)
  localparam logic [7:0] LADDR_STATUS2 = 8'h02;
  localparam logic [7:0] LADDR_FLAG_A  = 8'h03;
  localparam logic [7:0] LADDR_FLAG_B  = 8'h04;
  localparam logic [7:0] LADDR_POWER   = 8'h5d;
  localparam logic [7:0] LADDR_MASK_A  = 8'h64;
  localparam logic [7:0] LADDR_MASK_B  = 8'h65;

  // Power control byte fields
  localparam int PWR_OVERRIDE_BIT = 0;
  localparam int PWR_DOWN_BIT     = 1;

  // APB register byte addresses
  localparam logic [7:0] AADDR_STATUS = 8'h00;
  localparam logic [7:0] AADDR_FLAGS  = 8'h04;
  localparam logic [7:0] AADDR_MASKS  = 8'h08;
  localparam logic [7:0] AADDR_COND   = 8'h0c;

  // APB status register fields
  localparam int ST_DNR_BIT       = 0;
  localparam int ST_LOW_POWER_BIT = 1;
  localparam int ST_BUS_EN_BIT    = 2;
  localparam int ST_READY_BIT     = 3;
  localparam int ST_IRQ_BIT       = 4;
  localparam int ST_READY_FLAG_BIT = 5;

  // Request from the serial bus engine, one byte access per valid
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       stop;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmc_link_req_t;

  // Main-domain state mirrored to the link domain
  typedef struct packed {
    logic       dnr;
    logic       ready_flag;
    logic [7:0] flag_a;
    logic [7:0] flag_b;
    logic [7:0] mask_a;
    logic [7:0] mask_b;
    logic [1:0] pwr;
  } mmc_view_t;

  // Effects of one or more finished serial transactions
  typedef struct packed {
    logic       ready_clr;
    logic [7:0] clr_a;
    logic [7:0] clr_b;
    logic [1:0] mask_we;
    logic [7:0] mask_a;
    logic [7:0] mask_b;
    logic       pwr_we;
    logic [1:0] pwr;
  } mmc_cmd_t;

endpackage

/* rtl/mmc_top.sv */
// Module management control: reset/init, low power, bus select gating, flags and interrupt line
// Functional notes
// (RQ1) Become fully functional within 2000 ms of power-on or reset release.
// (RQ2) Reset pin low longer than 2 us resets; shorter pulses are ignored.
// (RQ3) Respond on the serial management bus within 2000 ms of power-on.
// (RQ4) After init clear data-not-ready bit and assert the interrupt line.
// (RQ5) Low-power pin asserted enters lower power level within 100 us.
// (RQ6) Interrupt line driven low within 200 ms of any triggering condition.
// (RQ7) Interrupt line released within 500 us after a read clears its flag.
// (RQ8) Loss-of-signal sets its flag and asserts interrupt within 100 ms.
// (RQ9) Any flag condition sets its flag and asserts interrupt within 200 ms.
// (RQ10) Setting a mask bit stops that flag asserting interrupt within 100 ms.
// (RQ11) Clearing a mask bit restores that flag's interrupt within 100 ms.
// (RQ12) Respond to serial transfers within 100 us of bus select assertion.
// (RQ13) Stop responding to serial transfers within 100 us of select deassertion.
// (RQ14) Power-down or override bit set enters lower power within 100 ms.
// (RQ15) Power-down bit cleared returns to full function within 300 ms.
// (RQ16) Control write timing counts from the end of that write transaction.
// (RQ17) Host reads flag bytes after the interrupt to find the cause.
// (RQ18) Flags stay latched until read; interrupt holds while unmasked flag set.
`timescale 1ns/10ps
`default_nettype none

module mmc_top #(
  parameter int INIT_CYCLES = mmc_pkg::INIT_CYCLES_DEF
) (
  // Main clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // Module pins
  input  wire logic                   module_reset_n,
  input  wire logic                   low_power_request,
  input  wire logic                   bus_select_n,
  input  wire logic [3:0]             rx_los_in,
  input  wire logic [3:0]             tx_fault_in,
  output logic                        irq_out_n,
  output logic                        low_power_out,
  // Serial bus engine side, link clock domain
  input  wire logic                   link_clock,
  input  wire logic                   link_reset,
  input  wire mmc_pkg::mmc_link_req_t link_req,
  output logic                        link_ack,
  output logic [7:0]                  link_rdata,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr
);
  import mmc_pkg::*;

  typedef struct packed {
    logic          sel_s1;
    logic          sel_s2;
    logic          rst_s1;
    logic          rst_s2;
    logic          lp_s1;
    logic          lp_s2;
    logic [7:0]    pin_s1;
    logic [7:0]    pin_s2;
    logic [7:0]    pin_prev;
    logic [7:0]    cond_reg;
    logic [7:0]    cond_prev;
    logic [7:0]    low_cnt;
    mmc_init_cnt_t init_cnt;
    logic          dnr;
    logic          serial_ready;
    logic          ready_flag;
    logic [7:0]    flag_a;
    logic [7:0]    flag_b;
    logic [7:0]    mask_a;
    logic [7:0]    mask_b;
    logic [1:0]    pwr;
    logic          req_s1;
    logic          req_s2;
    logic          ack;
    logic          bus_en;
    logic          irq_n;
    logic          lp_out;
    mmc_view_t     view;
    logic [31:0]   prdata;
    logic          perr;
  } mmc_main_t;

  typedef struct packed {
    logic       en_s1;
    logic       en_s2;
    logic       ack_s1;
    logic       ack_s2;
    mmc_view_t  view_s1;
    mmc_view_t  view_s2;
    logic [7:0] rdata;
    mmc_cmd_t   acc;
    logic       stop_seen;
    logic       req;
    mmc_cmd_t   payload;
  } mmc_link_t;

  mmc_main_t ms;
  mmc_main_t ms_d;
  mmc_link_t ls;
  mmc_link_t ls_d;

  // Byte seen by the host at a serial address
  function automatic logic [7:0] mmc_link_byte(input mmc_view_t v, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      LADDR_STATUS2: r = {7'h00, v.dnr};
      LADDR_FLAG_A:  r = v.flag_a;
      LADDR_FLAG_B:  r = v.flag_b;
      LADDR_POWER:   r = {6'h00, v.pwr};
      LADDR_MASK_A:  r = v.mask_a;
      LADDR_MASK_B:  r = v.mask_b;
      default:       r = 8'h00;
    endcase
    return r;
  endfunction

  // Known APB address
  function automatic logic mmc_apb_hit(input logic [7:0] a);
    return (a == AADDR_STATUS) || (a == AADDR_FLAGS) || (a == AADDR_MASKS) || (a == AADDR_COND);
  endfunction

  // Status word seen on the register bus
  function automatic logic [31:0] mmc_status_word(input mmc_main_t m);
    logic [31:0] w;
    w                    = 32'h0000_0000;
    w[ST_DNR_BIT]        = m.dnr;
    w[ST_LOW_POWER_BIT]  = m.lp_out;
    w[ST_BUS_EN_BIT]     = m.bus_en;
    w[ST_READY_BIT]      = m.serial_ready;
    w[ST_IRQ_BIT]        = ~m.irq_n;
    w[ST_READY_FLAG_BIT] = m.ready_flag;
    return w;
  endfunction

  // ---------------- Main clock domain ----------------
  always_comb begin
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic       in_reset;
    logic       hs;
    logic       rd_setup;
    logic       wr_access;
    mmc_cmd_t   cmd;
    logic       irq_any;
    logic       pwr_low;
    set_a     = 8'h00;
    set_b     = 8'h00;
    in_reset  = 1'b0;
    hs        = 1'b0;
    rd_setup  = 1'b0;
    wr_access = 1'b0;
    irq_any   = 1'b0;
    pwr_low   = 1'b0;
    cmd       = ls.payload;
    ms_d      = ms;

    // Pin synchronisers
    ms_d.sel_s1 = bus_select_n;
    ms_d.sel_s2 = ms.sel_s1;
    ms_d.rst_s1 = module_reset_n;
    ms_d.rst_s2 = ms.rst_s1;
    ms_d.lp_s1  = low_power_request;
    ms_d.lp_s2  = ms.lp_s1;
    ms_d.pin_s1 = {tx_fault_in, rx_los_in};
    ms_d.pin_s2 = ms.pin_s1;
    ms_d.pin_prev  = ms.pin_s2;
    ms_d.cond_prev = ms.cond_reg;

    // Rising conditions raise flags
    set_a = ms.pin_s2 & ~ms.pin_prev;                                  // [RQ8] [RQ9]
    set_b = ms.cond_reg & ~ms.cond_prev;                               // [RQ9]

    // Reset pin pulse qualification
    // Counter saturates so a long low never wraps into a short pulse
    if (ms.rst_s2) begin
      ms_d.low_cnt = 8'h00;
    end else if (ms.low_cnt != LOW_CNT_MAX) begin
      ms_d.low_cnt = ms.low_cnt + 8'h01;
    end
    in_reset = ~ms.rst_s2 && (ms.low_cnt > RESET_MIN_CYCLES);          // [RQ2]

    // Commands from finished serial transactions
    // Payload holds still while req and ack differ, so it is read without resync
    ms_d.req_s1 = ls.req;
    ms_d.req_s2 = ms.req_s1;
    hs = ms.req_s2 != ms.ack;
    if (hs) begin
      ms_d.ack = ms.req_s2;
    end
    if (!hs) begin
      cmd = '0;
    end

    // Latched flags, hardware set wins over clear on read
    ms_d.flag_a = (ms.flag_a & ~cmd.clr_a) | set_a;                    // [RQ18] [RQ7]
    ms_d.flag_b = (ms.flag_b & ~cmd.clr_b) | set_b;                    // [RQ18] [RQ7]
    if (cmd.ready_clr) begin
      ms_d.ready_flag = 1'b0;                                          // [RQ7]
    end
    if (cmd.mask_we[0]) begin
      ms_d.mask_a = cmd.mask_a;                                        // [RQ10] [RQ11] [RQ16]
    end
    if (cmd.mask_we[1]) begin
      ms_d.mask_b = cmd.mask_b;                                        // [RQ10] [RQ11] [RQ16]
    end
    if (cmd.pwr_we) begin
      ms_d.pwr = cmd.pwr;                                              // [RQ14] [RQ15] [RQ16]
    end

    // Initialization sequence
    if (in_reset) begin
      ms_d.init_cnt     = '0;
      ms_d.dnr          = 1'b1;
      ms_d.serial_ready = 1'b0;
      ms_d.ready_flag   = 1'b0;
      ms_d.flag_a       = 8'h00;
      ms_d.flag_b       = 8'h00;
      ms_d.mask_a       = 8'h00;
      ms_d.mask_b       = 8'h00;
      ms_d.pwr          = 2'b00;
    end else if (ms.dnr) begin
      if (ms.init_cnt == mmc_init_cnt_t'(INIT_CYCLES - 1)) begin
        ms_d.dnr          = 1'b0;                                      // [RQ1] [RQ4]
        ms_d.serial_ready = 1'b1;                                      // [RQ3]
        ms_d.ready_flag   = 1'b1;                                      // [RQ4]
      end else begin
        ms_d.init_cnt = ms.init_cnt + mmc_init_cnt_t'(1);
      end
    end

    // Serial bus gating by select and readiness
    ms_d.bus_en = ~ms.sel_s2 & ms.serial_ready & ~in_reset;            // [RQ12] [RQ13] [RQ3]

    // Interrupt line and power level
    irq_any = ms.ready_flag
            | (|(ms.flag_a & ~ms.mask_a))
            | (|(ms.flag_b & ~ms.mask_b));                             // [RQ6] [RQ10] [RQ11] [RQ18]
    ms_d.irq_n = ~irq_any;
    pwr_low = ms.pwr[PWR_OVERRIDE_BIT] | ms.pwr[PWR_DOWN_BIT];         // [RQ14] [RQ15]
    ms_d.lp_out = ms.lp_s2 | pwr_low;                                  // [RQ5]

    // Snapshot for the link domain
    // Each bit is synchronised alone; a one-cycle skew between bits is accepted
    ms_d.view.dnr        = ms.dnr;
    ms_d.view.ready_flag = ms.ready_flag;
    ms_d.view.flag_a     = ms.flag_a;
    ms_d.view.flag_b     = ms.flag_b;
    ms_d.view.mask_a     = ms.mask_a;
    ms_d.view.mask_b     = ms.mask_b;
    ms_d.view.pwr        = ms.pwr;

    // APB slave: data prepared in setup, answered in access phase
    rd_setup  = psel && !penable;
    wr_access = psel && penable && pwrite;
    if (rd_setup) begin
      ms_d.perr   = ~mmc_apb_hit(paddr);
      ms_d.prdata = 32'h0000_0000;
      case (paddr)
        AADDR_STATUS: ms_d.prdata = mmc_status_word(ms);
        AADDR_FLAGS: ms_d.prdata = {16'h0000, ms.flag_b, ms.flag_a};
        AADDR_MASKS: ms_d.prdata = {16'h0000, ms.mask_b, ms.mask_a};
        AADDR_COND:  ms_d.prdata = {24'h000000, ms.cond_reg};
        default:     ms_d.prdata = 32'h0000_0000;
      endcase
    end
    if (wr_access && (paddr == AADDR_COND)) begin
      ms_d.cond_reg = pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      // Pins idle, data not ready, interrupt line released
      ms              <= '0;
      ms.sel_s1       <= 1'b1;
      ms.sel_s2       <= 1'b1;
      ms.rst_s1       <= 1'b1;
      ms.rst_s2       <= 1'b1;
      ms.dnr          <= 1'b1;
      ms.irq_n        <= 1'b1;
      ms.view.dnr     <= 1'b1;
    end else begin
      ms <= ms_d;
    end
  end

  assign irq_out_n     = ms.irq_n;
  assign low_power_out = ms.lp_out;
  assign prdata        = ms.prdata;
  assign pready        = psel & penable;
  assign pslverr       = psel & penable & ms.perr;

  // ---------------- Link clock domain ----------------
  always_comb begin
    logic     busy;
    logic     take;
    logic     launch;
    mmc_cmd_t base;
    busy   = 1'b0;
    take   = 1'b0;
    launch = 1'b0;
    base   = '0;
    ls_d   = ls;

    ls_d.en_s1   = ms.bus_en;
    ls_d.en_s2   = ls.en_s1;
    ls_d.ack_s1  = ms.ack;
    ls_d.ack_s2  = ls.ack_s1;
    ls_d.view_s1 = ms.view;
    ls_d.view_s2 = ls.view_s1;

    busy   = ls.req != ls.ack_s2;
    take   = link_req.valid && ls.en_s2;                               // [RQ12] [RQ13]
    // A batch launches only once the main side has taken the previous one
    launch = ls.stop_seen && !busy;                                    // [RQ16]
    base   = launch ? mmc_cmd_t'('0) : ls.acc;

    if (launch) begin
      ls_d.payload   = ls.acc;
      ls_d.req       = ~ls.req;
      ls_d.stop_seen = 1'b0;
    end

    // Bytes taken while a batch waits join that batch; bytes taken in the launch cycle start the next one
    if (take && !link_req.write) begin
      ls_d.rdata = mmc_link_byte(ls.view_s2, link_req.addr);
      case (link_req.addr)
        LADDR_STATUS2: base.ready_clr = base.ready_clr | ls.view_s2.ready_flag; // [RQ7]
        LADDR_FLAG_A:  base.clr_a     = base.clr_a | ls.view_s2.flag_a;         // [RQ7] [RQ17]
        LADDR_FLAG_B:  base.clr_b     = base.clr_b | ls.view_s2.flag_b;         // [RQ7] [RQ17]
        default:       base.clr_a     = base.clr_a;
      endcase
    end
    if (take && link_req.write) begin
      case (link_req.addr)
        LADDR_MASK_A: begin
          base.mask_a     = link_req.wdata;
          base.mask_we[0] = 1'b1;
        end
        LADDR_MASK_B: begin
          base.mask_b     = link_req.wdata;
          base.mask_we[1] = 1'b1;
        end
        LADDR_POWER: begin
          base.pwr    = link_req.wdata[1:0];
          base.pwr_we = 1'b1;
        end
        default: base.pwr_we = base.pwr_we;
      endcase
    end
    ls_d.acc = base;
    if (link_req.stop && ls.en_s2) begin
      ls_d.stop_seen = 1'b1;                                           // [RQ16]
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      ls              <= '0;
      // View shows not ready until the first snapshot arrives
      ls.view_s1.dnr  <= 1'b1;
      ls.view_s2.dnr  <= 1'b1;
    end else begin
      ls <= ls_d;
    end
  end

  assign link_ack   = link_req.valid & ls.en_s2;
  assign link_rdata = ls.rdata;

endmodule

`default_nettype wire

/* bench/mmc_top_asserts.sv */
// Port-level checks of the module management control block
`timescale 1ns/10ps
`default_nettype none
module mmc_top_asserts #(
  parameter int INIT_CYCLES = 50
) (
  // Main domain
  input wire logic                   clock,
  input wire logic                   reset,
  input wire logic                   module_reset_n,
  input wire logic                   low_power_request,
  input wire logic                   bus_select_n,
  input wire logic                   irq_out_n,
  input wire logic                   low_power_out,
  // Link domain
  input wire logic                   link_clock,
  input wire logic                   link_reset,
  input wire mmc_pkg::mmc_link_req_t link_req,
  input wire logic                   link_ack,
  input wire logic [7:0]             link_rdata
);
  import mmc_pkg::*;
  // Cycles since power-on reset release, and length of the reset pin low
  int since_q;
  int low_q;
  int desel_q;
  // Link cycles since the select pin went high
  always_ff @(posedge link_clock) begin
    desel_q <= (link_reset || !bus_select_n) ? 0 : (desel_q < 20 ? desel_q + 1 : desel_q);
  end
  always_ff @(posedge clock) begin
    since_q <= reset ? 0 : (since_q < INIT_CYCLES + 9 ? since_q + 1 : since_q);
    low_q   <= (reset || module_reset_n) ? 0 : (low_q < 40 ? low_q + 1 : low_q);
  end
  property p_rst_out;
    @(posedge clock) disable iff (reset) $fell(reset) |-> irq_out_n && !low_power_out;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  property p_init_wait;
    @(posedge clock) disable iff (reset) since_q < INIT_CYCLES - 2 |-> irq_out_n;
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("ready signalled too early");
  property p_init_done;
    @(posedge clock) disable iff (reset) since_q == INIT_CYCLES + 6 |-> !irq_out_n;
  endproperty
  a_init_done: assert property (p_init_done) else $error("ready not signalled");
  property p_lp_pin;
    @(posedge clock) disable iff (reset) low_power_request [*6] |-> low_power_out;
  endproperty
  a_lp_pin: assert property (p_lp_pin) else $error("low power pin not followed");
  property p_soft;
    @(posedge clock) disable iff (reset) low_q == 30 |-> irq_out_n && !low_power_out;
  endproperty
  a_soft: assert property (p_soft) else $error("long reset pulse did not reset");
  property p_desel;
    @(posedge link_clock) disable iff (link_reset) desel_q == 20 |-> !link_ack;
  endproperty
  a_desel: assert property (p_desel) else $error("answer while deselected");
  property p_ack_valid;
    @(posedge link_clock) disable iff (link_reset) link_ack |-> link_req.valid;
  endproperty
  a_ack_valid: assert property (p_ack_valid) else $error("answer without request");
  property p_rdata0;
    @(posedge link_clock) disable iff (link_reset)
      link_ack && !link_req.write && link_req.addr == 8'h07 |=> link_rdata == 8'h00;
  endproperty
  a_rdata0: assert property (p_rdata0) else $error("unused byte not zero");
endmodule
`default_nettype wire

/* bench/mmc_host_model.sv */
// Host board controller model on the serial bus engine side
`timescale 1ns/10ps
`default_nettype none
module mmc_host_model (
  // Link domain
  input  wire logic                   link_clock,
  output var mmc_pkg::mmc_link_req_t  link_req,
  input  wire logic                   link_ack,
  input  wire logic [7:0]             link_rdata
);
  import mmc_pkg::*;
  initial link_req = '0;
  // One byte access, then the stop pulse and an idle gap
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input int gap,
                      output logic [7:0] rd, output logic ack);
    @(posedge link_clock);
    link_req <= '{1'b1, wr, 1'b0, a, d};
    @(posedge link_clock);
    ack = link_ack;
    // Idle lines do not keep the old value
    link_req <= '{1'b0, wr, 1'b0, ~a, ~d};
    @(posedge link_clock);
    rd = link_rdata;
    link_req.stop <= 1'b1;
    @(posedge link_clock);
    link_req.stop <= 1'b0;
    repeat (gap) @(posedge link_clock);
  endtask
endmodule
`default_nettype wire

/* bench/mmc_top_tb.sv */
// Self-checking bench of the module management control block
`timescale 1ns/10ps
`default_nettype none
module mmc_top_tb;
  import mmc_pkg::*;
  logic           clock = 0, reset = 1, link_clock = 0, link_reset = 1;
  logic           module_reset_n, low_power_request, bus_select_n, irq_out_n, low_power_out;
  logic [3:0]     rx_los_in, tx_fault_in;
  mmc_link_req_t  link_req;
  logic           link_ack, psel, penable, pwrite, pready, pslverr, ack, err;
  logic [7:0]     link_rdata, paddr, lrd, e, v;
  logic [31:0]    pwdata, prdata, rd;
  int             n_mismatch = 0, checked = 0, seed = 33, k, b;
  int             q_flag[$];
  always #50 clock = ~clock;
  always #16 link_clock = ~link_clock;
  mmc_top #(.INIT_CYCLES(50)) mmc_top_i (.clock, .reset, .module_reset_n, .low_power_request, .bus_select_n,
    .rx_los_in, .tx_fault_in, .irq_out_n, .low_power_out, .link_clock, .link_reset, .link_req, .link_ack,
    .link_rdata, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  mmc_host_model mmc_host_model_i (.link_clock, .link_req, .link_ack, .link_rdata);
  task automatic give_verdict;
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_pin(input int which, input logic lvl);
    int n;
    for (n = 0; n < 400 && (which ? low_power_out : irq_out_n) !== lvl; n++) @(posedge clock);
    if (n == 400) begin
      n_mismatch++;
      give_verdict;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n == 20) begin
      n_mismatch++;
      give_verdict;
    end
  endtask
  task automatic lnk(input logic wr, input logic [7:0] a, input logic [7:0] d);
    mmc_host_model_i.xfer(wr, a, d, ($random(seed) & 7) + 1, lrd, ack);
  endtask
  initial begin
    {module_reset_n, low_power_request, bus_select_n} = 3'b101;
    {rx_los_in, tx_fault_in, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge clock);
    {reset, link_reset} <= 2'b00;
    apb(0, AADDR_STATUS, 0);
    cmp(rd & 32'h21, 32'h01);
    lnk(0, LADDR_STATUS2, 0);
    cmp(ack, 0);
    wait_pin(0, 0);
    apb(0, AADDR_STATUS, 0);
    cmp(rd & 32'h21, 32'h20);
    bus_select_n <= 1'b0;
    repeat (10) @(posedge clock);
    lnk(0, 8'h07, 8'h5a);
    cmp({ack, lrd}, 9'h100);
    lnk(0, LADDR_STATUS2, 0);
    cmp(lrd[0], 0);
    wait_pin(0, 1);
    for (k = 0; k < 4; k++) begin
      b = $random(seed) & 3;
      e = 8'(1 << (b + 4 * k[0]));
      lnk(1, LADDR_MASK_A, k[1] ? 8'hff : 8'h00);
      repeat (20) @(posedge clock);
      {tx_fault_in, rx_los_in} <= e;
      q_flag.push_back(e);
      if (k[1]) begin
        repeat (40) @(posedge clock);
        cmp(irq_out_n, 1);
        lnk(1, LADDR_MASK_A, 0);
      end
      wait_pin(0, 0);
      {tx_fault_in, rx_los_in} <= 8'h00;
      repeat (20) @(posedge clock);
      cmp(irq_out_n, 0);
      apb(0, AADDR_FLAGS, 0);
      cmp(rd, q_flag[0]);
      lnk(0, LADDR_FLAG_A, 0);
      cmp(lrd, q_flag.pop_front());
      wait_pin(0, 1);
      apb(0, AADDR_FLAGS, 0);
      cmp(rd, 0);
    end
    v = ($random(seed) & 8'hff) | 8'h01;
    apb(1, AADDR_COND, {24'h0, v});
    q_flag.push_back(v);
    wait_pin(0, 0);
    lnk(0, LADDR_FLAG_B, 0);
    cmp(lrd, q_flag.pop_front());
    wait_pin(0, 1);
    for (k = 1; k < 3; k++) begin
      lnk(1, LADDR_POWER, k[7:0]);
      wait_pin(1, 1);
      lnk(1, LADDR_POWER, 0);
      wait_pin(1, 0);
    end
    low_power_request <= 1'b1;
    wait_pin(1, 1);
    low_power_request <= 1'b0;
    apb(0, 8'h10, 0);
    cmp(err, 1);
    cmp(rd, 0);
    lnk(1, LADDR_MASK_B, 8'h3c);
    module_reset_n <= 1'b0;
    repeat (15) @(posedge clock);
    module_reset_n <= 1'b1;
    repeat (10) @(posedge clock);
    apb(0, AADDR_MASKS, 0);
    cmp(rd, 32'h3c00);
    lnk(1, LADDR_POWER, 8'(1 << PWR_DOWN_BIT));
    wait_pin(1, 1);
    module_reset_n <= 1'b0;
    repeat (35) @(posedge clock);
    apb(0, AADDR_STATUS, 0);
    cmp(rd & 32'h21, 32'h01);
    module_reset_n <= 1'b1;
    wait_pin(0, 0);
    apb(0, AADDR_MASKS, 0);
    cmp(rd, 0);
    cmp(low_power_out, 0);
    bus_select_n <= 1'b1;
    repeat (10) @(posedge clock);
    lnk(0, 8'h07, 0);
    cmp(ack, 0);
    give_verdict;
  end
endmodule
bind mmc_top mmc_top_asserts #(.INIT_CYCLES(INIT_CYCLES)) mmc_top_asserts_i (.clock, .reset, .module_reset_n,
  .low_power_request, .bus_select_n, .irq_out_n, .low_power_out, .link_clock, .link_reset, .link_req,
  .link_ack, .link_rdata);
`default_nettype wire
